// [logic/cdps_top.sv]
// Clock divide, oscillator control and power status registers with timed-access key.
// Assumes an Avalon-MM master on core_clk_i and core event pulses on the same clock.
//
// Notes on behaviour
// - Divide code 01/10/11 gives 4/64/1024 clocks
// - Switchback forces divide-by-4 on interrupt or serial
// - Interrupt switchback at jump into service routine
// - Receive switchback at instruction after start edge
// - Crystal disable accepted only on RC oscillator
// - Clearing disable restarts crystal, warm-up then sets
// - Warm-up completes after 65536 crystal clocks
// - Every crystal restart clears warm-up status
// - Power-on reset leaves warm-up status set
// - Crystal select blocked while warm-up status clear
// - Suppress bit holds latch strobe off internally
// - External accesses always drive latch strobe
// - Enable bit maps on-chip 1KB data SRAM
// - In-service bits set in service, cleared on return
// - Activity bits set while busy, cleared by flag
// - Divide writes ignored when busy and switchback on
// - Unlock opens protected writes for three machine cycles
// - Wait enable samples wait pin on external moves
`timescale 1ns/1ps
`default_nettype none
`include "cdps_map.svh"

module cdps_top #(
  parameter int unsigned WARM_CLOCKS = `CDPS_WARM_CLOCKS  // Crystal warm-up length
) (
  // Clock and reset
  input  wire  logic        core_clk_i,
  input  wire  logic        arst_n_i,
  // Avalon-MM slave
  input  wire  logic [9:0]  avs_address_i,
  input  wire  logic        avs_read_i,
  input  wire  logic        avs_write_i,
  input  wire  logic [31:0] avs_writedata_i,
  input  wire  logic [3:0]  avs_byteenable_i,
  output logic       [31:0] avs_readdata_o,
  output logic              avs_waitrequest_o,
  // Core events, one-cycle pulses
  input  wire  logic        ext_irq_vector_i,
  input  wire  logic        serial_rx_switch_i,
  input  wire  logic        isr_enter_hi_i,
  input  wire  logic        isr_enter_lo_i,
  input  wire  logic        return_from_interrupt_i,
  input  wire  logic [3:0]  serial_activity_start_i,
  input  wire  logic [3:0]  serial_flag_set_i,
  input  wire  logic        power_down_exit_i,
  // Core access levels
  input  wire  logic        ale_request_i,
  input  wire  logic        ext_mem_access_i,
  input  wire  logic        external_data_move_i,
  // Pins
  input  wire  logic        crystal_clk_i,
  input  wire  logic        wait_n_i,
  // Control outputs
  output logic       [1:0]  clock_divide_sel_o,
  output logic              machine_cycle_tick_o,
  output logic              crystal_disable_o,
  output logic              crystal_source_select_o,
  output logic              latch_strobe_o,
  output logic              onchip_xram_enable_o,
  output logic              xdata_wait_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [1:0]         cd_q;        // Divide code
  logic               swb_q;       // Switchback enable
  logic               crystal_disable_q;     // Crystal disable
  logic               ale_sup_q;   // Latch strobe suppress
  logic               xram_en_q;   // On-chip SRAM enable
  logic               xt_sel_q;    // Crystal source select
  logic               ws_q;        // Wait-state enable, protected
  logic               hip_q;       // High priority in service
  logic               lip_q;       // Low priority in service
  logic               warm_q;      // Crystal warm-up done
  logic [3:0]         act_q;       // Serial activity bits
  logic [9:0]         div_cnt_q;   // Machine-cycle divider
  logic [9:0]         div_lim;     // Divider terminal count
  logic [16:0]        warm_cnt_q;  // Crystal edges seen
  logic               warm_run_q;  // Warm-up in progress
  logic [2:0]         xclk_sync_q; // Crystal clock synchroniser
  logic               xclk_stb_q;  // Filtered crystal level
  logic               xclk_rise;   // Crystal rising edge
  logic [2:0]         wait_sync_q; // Wait pin synchroniser
  logic               wait_n_stb_q;// Filtered wait level
  cdps_pkg::cdps_key_t key_q;      // Unlock state
  logic [1:0]         win_q;       // Machine cycles left open

  // Bus decode
  logic [7:0] idx;
  logic       wr_acc;
  logic       sb_event;
  logic       cd_wr;
  logic [7:0] wdat;
  assign idx      = avs_address_i[9:2];
  assign wdat     = avs_writedata_i[7:0];
  assign wr_acc   = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
  // Enabled interrupt vector, receive start, or transmit start forces fast divide
  assign sb_event = swb_q & (ext_irq_vector_i | serial_rx_switch_i
                             | serial_activity_start_i[3] | serial_activity_start_i[1]);
  assign cd_wr    = wr_acc & (idx == `CDPS_IDX_PWR_MGMT);

  // ----------------------------------------
  // Avalon handshake
  // ----------------------------------------
  // One wait cycle per access; the request is taken when waitrequest is low
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
    end
  end

  // Read data loaded together with the waitrequest drop; unmapped reads zero
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i & avs_waitrequest_o) begin
      if (idx == `CDPS_IDX_PWR_MGMT) begin
        avs_readdata_o <= {24'h00_0000, cd_q, swb_q, 1'b0, crystal_disable_q, ale_sup_q, 1'b0, xram_en_q};
      end else if (idx == `CDPS_IDX_STATUS) begin
        avs_readdata_o <= {24'h00_0000, 1'b0, hip_q, lip_q, warm_q, act_q};
      end else if (idx == `CDPS_IDX_MAP_WAIT) begin
        avs_readdata_o <= {31'h0000_0000, ws_q};
      end else if (idx == `CDPS_IDX_OSC_CTRL) begin
        avs_readdata_o <= {31'h0000_0000, xt_sel_q};
      end else begin
        // Key register is write-only
        avs_readdata_o <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // Clock divide and machine-cycle tick
  // ----------------------------------------
  // Switchback beats a software write; reserved code and busy writes with switchback on ignored
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cd_q <= `CDPS_RST_CD;
    end else if (sb_event) begin
      cd_q <= `CDPS_CD_DIV4;
    end else if (cd_wr && !(swb_q && (|act_q))
                 && wdat[`CDPS_PM_CD_HI:`CDPS_PM_CD_LO] != `CDPS_CD_RSVD) begin
      // Slow-to-slow moves are left to software to route via divide-by-4
      cd_q <= wdat[`CDPS_PM_CD_HI:`CDPS_PM_CD_LO];
    end
  end

  // Terminal count per divide code
  always_comb begin
    if (cd_q == `CDPS_CD_DIV64) begin
      div_lim = `CDPS_LIM_DIV64;
    end else if (cd_q == `CDPS_CD_DIV1024) begin
      div_lim = `CDPS_LIM_DIV1024;
    end else begin
      div_lim = `CDPS_LIM_DIV4;
    end
  end

  // Compare with >= so a switch to a shorter divide never overshoots
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_cnt_q            <= 10'h000;
      machine_cycle_tick_o <= 1'b0;
    end else begin
      div_cnt_q            <= (div_cnt_q >= div_lim) ? 10'h000 : div_cnt_q + 10'h001;
      machine_cycle_tick_o <= (div_cnt_q >= div_lim);
    end
  end

  // ----------------------------------------
  // Plain power management bits
  // ----------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      swb_q     <= 1'b0;
      ale_sup_q <= 1'b0;
      xram_en_q <= 1'b0;
    end else if (cd_wr) begin
      swb_q     <= wdat[`CDPS_PM_SWB];
      ale_sup_q <= wdat[`CDPS_PM_ALE_SUP];
      xram_en_q <= wdat[`CDPS_PM_XRAM_EN];
    end
  end

  // ----------------------------------------
  // Crystal control and warm-up
  // ----------------------------------------
  // Disable may only rise while running from RC; clearing is always allowed
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      crystal_disable_q <= 1'b0;
    end else if (cd_wr && (!wdat[`CDPS_PM_CRYSTAL_DISABLE] || !xt_sel_q)) begin
      crystal_disable_q <= wdat[`CDPS_PM_CRYSTAL_DISABLE];
    end
  end

  // Crystal select cannot be set before the crystal has warmed up
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      xt_sel_q <= 1'b0;
    end else if (wr_acc && idx == `CDPS_IDX_OSC_CTRL
                 && (!wdat[`CDPS_OC_XT_SEL] || warm_q)) begin
      xt_sel_q <= wdat[`CDPS_OC_XT_SEL];
    end
  end

  // Crystal clock is foreign: three stages, level taken when last two agree
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      xclk_sync_q <= 3'h0;
      xclk_stb_q  <= 1'b0;
    end else begin
      xclk_sync_q <= {xclk_sync_q[1:0], crystal_clk_i};
      if (xclk_sync_q[1] == xclk_sync_q[2]) begin
        xclk_stb_q <= xclk_sync_q[2];
      end
    end
  end
  assign xclk_rise = (xclk_sync_q[1] == xclk_sync_q[2]) & xclk_sync_q[2] & ~xclk_stb_q;

  // Restart on disable release or power-down exit; power-on leaves status set
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      warm_q     <= 1'b1;
      warm_run_q <= 1'b0;
      warm_cnt_q <= 17'h0_0000;
    end else if ((cd_wr && crystal_disable_q && !wdat[`CDPS_PM_CRYSTAL_DISABLE]) || power_down_exit_i) begin
      warm_q     <= 1'b0;
      warm_run_q <= 1'b1;
      warm_cnt_q <= 17'h0_0000;
    end else if (warm_run_q && !crystal_disable_q && xclk_rise) begin
      if (warm_cnt_q == 17'(WARM_CLOCKS - 1)) begin
        warm_q     <= 1'b1;
        warm_run_q <= 1'b0;
      end
      warm_cnt_q <= warm_cnt_q + 17'h0_0001;
    end
  end

  // ----------------------------------------
  // Interrupt in-service bits
  // ----------------------------------------
  // Return clears the highest level in service; a new entry wins over it
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hip_q <= 1'b0;
      lip_q <= 1'b0;
    end else begin
      if (isr_enter_hi_i) begin
        hip_q <= 1'b1;
      end else if (return_from_interrupt_i && hip_q) begin
        hip_q <= 1'b0;
      end
      if (isr_enter_lo_i) begin
        lip_q <= 1'b1;
      end else if (return_from_interrupt_i && !hip_q) begin
        lip_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Serial activity bits, one per port and direction
  // ----------------------------------------
  // Order 3..0: port1 tx, port1 rx, port0 tx, port0 rx; start wins over flag
  for (genvar g = 0; g < 4; g++) begin : g_act
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        act_q[g] <= 1'b0;
      end else if (serial_activity_start_i[g]) begin
        act_q[g] <= 1'b1;
      end else if (serial_flag_set_i[g]) begin
        act_q[g] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Timed-access key
  // ----------------------------------------
  // Any other write between the two key bytes cancels the sequence
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      key_q <= cdps_pkg::KEY_IDLE;
      win_q <= 2'h0;
    end else begin
      case (key_q)
        cdps_pkg::KEY_IDLE: begin
          if (wr_acc && idx == `CDPS_IDX_KEY && wdat == `CDPS_KEY_FIRST) begin
            key_q <= cdps_pkg::KEY_ARMED;
          end
        end
        cdps_pkg::KEY_ARMED: begin
          if (wr_acc && idx == `CDPS_IDX_KEY && wdat == `CDPS_KEY_SECOND) begin
            key_q <= cdps_pkg::KEY_OPEN;
            win_q <= `CDPS_WIN_CYCLES;
          end else if (wr_acc) begin
            key_q <= cdps_pkg::KEY_IDLE;
          end
        end
        cdps_pkg::KEY_OPEN: begin
          if (machine_cycle_tick_o) begin
            win_q <= win_q - 2'h1;
            if (win_q == 2'h1) begin
              key_q <= cdps_pkg::KEY_IDLE;
            end
          end
        end
        default: begin
          key_q <= cdps_pkg::KEY_IDLE;
        end
      endcase
    end
  end

  // Protected bit: only written while the window stands open
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ws_q <= 1'b0;
    end else if (wr_acc && idx == `CDPS_IDX_MAP_WAIT && key_q == cdps_pkg::KEY_OPEN) begin
      ws_q <= wdat[`CDPS_MW_WS];
    end
  end

  // ----------------------------------------
  // Pin side outputs
  // ----------------------------------------
  // Wait pin is foreign: three stages, level taken when last two agree
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_sync_q  <= 3'h7;
      wait_n_stb_q <= 1'b1;
    end else begin
      wait_sync_q <= {wait_sync_q[1:0], wait_n_i};
      if (wait_sync_q[1] == wait_sync_q[2]) begin
        wait_n_stb_q <= wait_sync_q[2];
      end
    end
  end

  // Registered outputs; latch strobe always runs on external accesses
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latch_strobe_o       <= 1'b0;
      xdata_wait_o         <= 1'b0;
      onchip_xram_enable_o <= 1'b0;
      crystal_disable_o    <= 1'b0;
      crystal_source_select_o <= 1'b0;
      clock_divide_sel_o   <= `CDPS_RST_CD;
    end else begin
      latch_strobe_o       <= ale_request_i & (ext_mem_access_i | ~ale_sup_q);
      xdata_wait_o         <= ws_q & external_data_move_i & ~wait_n_stb_q;
      onchip_xram_enable_o <= xram_en_q;
      crystal_disable_o    <= crystal_disable_q;
      crystal_source_select_o <= xt_sel_q;
      clock_divide_sel_o   <= cd_q;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Cycles spent with the window open; three ticks at divide-by-1024 is the longest case
  logic [11:0] open_cnt_q;
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      open_cnt_q <= 12'h000;
    end else if (key_q == cdps_pkg::KEY_OPEN) begin
      open_cnt_q <= open_cnt_q + 12'h001;
    end else begin
      open_cnt_q <= 12'h000;
    end
  end

  chk_div_code_legal: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    cd_q != `CDPS_CD_RSVD) else $error("reserved divide code held");
  chk_tick_spacing: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    machine_cycle_tick_o |=> !machine_cycle_tick_o [*3]) else $error("machine ticks too close");
  chk_switch_fast: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    swb_q && (ext_irq_vector_i || serial_rx_switch_i) |=> cd_q == `CDPS_CD_DIV4)
    else $error("switchback did not force divide by 4");
  chk_cd_locked: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    cd_wr && swb_q && (|act_q) && !sb_event |=> $stable(cd_q)) else $error("divide changed while busy");
  chk_crystal_disable_rc_only: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    $rose(crystal_disable_q) |-> !$past(xt_sel_q)) else $error("crystal disabled while on crystal");
  chk_warm_restart: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    $fell(crystal_disable_q) |-> !warm_q ##1 !warm_q) else $error("warm status not cleared on restart");
  chk_sel_needs_warm: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    $rose(xt_sel_q) |-> $past(warm_q)) else $error("crystal selected before warm-up");
  chk_ale_external: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    ale_request_i && ext_mem_access_i |=> latch_strobe_o) else $error("strobe missing on external access");
  chk_ale_suppress: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    ale_request_i && !ext_mem_access_i && ale_sup_q |=> !latch_strobe_o) else $error("strobe not suppressed");
  chk_ws_protected: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    $changed(ws_q) |-> $past(key_q) == cdps_pkg::KEY_OPEN) else $error("protected bit written while locked");
  chk_window_close: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    open_cnt_q <= `CDPS_WIN_MAX_CLOCKS) else $error("window stayed open");
  chk_isr_high: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    isr_enter_hi_i |=> hip_q) else $error("high in-service not set");
  chk_act_clear: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    serial_flag_set_i[0] && !serial_activity_start_i[0] |=> !act_q[0]) else $error("activity not cleared");
  chk_wait_use: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    xdata_wait_o |-> $past(ws_q) && $past(external_data_move_i)) else $error("wait outside external move");

  cov_switchback: cover property (@(posedge core_clk_i) disable iff (!arst_n_i)
    cd_q == `CDPS_CD_DIV1024 ##1 sb_event ##1 cd_q == `CDPS_CD_DIV4);
  cov_unlock: cover property (@(posedge core_clk_i) disable iff (!arst_n_i)
    key_q == cdps_pkg::KEY_ARMED ##[1:8] key_q == cdps_pkg::KEY_OPEN);
  cov_warm_done: cover property (@(posedge core_clk_i) disable iff (!arst_n_i) $rose(warm_q));
  cov_ws_set: cover property (@(posedge core_clk_i) disable iff (!arst_n_i) $rose(ws_q));

endmodule // cdps_top
`default_nettype wire

// [logic/cdps_map.svh]
// Register indices, field positions, reset values and counts for the clock divide block.
// Assumes inclusion by the top module and the bench by bare name.
`ifndef CDPS_MAP_SVH
`define CDPS_MAP_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define CDPS_IDX_OSC_CTRL     8'hc3
`define CDPS_IDX_PWR_MGMT     8'hc4
`define CDPS_IDX_STATUS       8'hc5
`define CDPS_IDX_MAP_WAIT     8'hc6
`define CDPS_IDX_KEY          8'hc7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CDPS_PM_CD_HI         7
`define CDPS_PM_CD_LO         6
`define CDPS_PM_SWB           5
`define CDPS_PM_CRYSTAL_DISABLE         3
`define CDPS_PM_ALE_SUP       2
`define CDPS_PM_XRAM_EN       0
`define CDPS_ST_HIP           6
`define CDPS_ST_LIP           5
`define CDPS_ST_CRYSTAL_WARM_STATUS          4
`define CDPS_MW_WS            0
`define CDPS_OC_XT_SEL        0

// ----------------------------------------
// Divide codes and machine-cycle limits
// ----------------------------------------
`define CDPS_CD_RSVD          2'h0
`define CDPS_CD_DIV4          2'h1
`define CDPS_CD_DIV64         2'h2
`define CDPS_CD_DIV1024       2'h3
`define CDPS_LIM_DIV4         10'h003
`define CDPS_LIM_DIV64        10'h03f
`define CDPS_LIM_DIV1024      10'h3ff

// ----------------------------------------
// Reset values, keys and timing counts
// ----------------------------------------
`define CDPS_RST_CD           2'h1
`define CDPS_KEY_FIRST        8'haa
`define CDPS_KEY_SECOND       8'h55
`define CDPS_WIN_CYCLES       2'h3
`define CDPS_WARM_CLOCKS      65536
`define CDPS_WIN_MAX_CLOCKS   12'hc00

`endif

// [logic/cdps_pkg.sv]
// Types shared by the clock divide and power status block.
// Assumes the map header is on the include path.
`default_nettype none
package cdps_pkg;

  // ----------------------------------------
  // Unlock sequence states, Gray along the path
  // ----------------------------------------
  typedef enum logic [1:0] {
    KEY_IDLE  = 2'h0,
    KEY_ARMED = 2'h1,
    KEY_OPEN  = 2'h3
  } cdps_key_t;

endpackage
`default_nettype wire

// [tb/cdps_xtal_model.sv]
// Crystal oscillator model standing at the far side of the clock block.
// Assumes the bench loops the block's crystal disable output back into it.
`timescale 1ns/1ps
`default_nettype none
module cdps_xtal_model (
  // Control from the block
  input  wire logic crystal_disable_i,
  // Pin back to the block
  output logic      crystal_clk_o
);
  // ----------------
  // Oscillation
  // ----------------
  // Ten core clocks a period, slower than core_clk/4, so no edge is lost
  initial begin
    crystal_clk_o = 1'b0;
    forever begin
      #250;
      // Stands still low while stopped, as a dead crystal would
      crystal_clk_o = crystal_disable_i ? 1'b0 : ~crystal_clk_o;
    end
  end
endmodule // cdps_xtal_model
`default_nettype wire

// [tb/clock_divide_power_status_tb.sv]
// Self-checking bench for the clock divide and power status block.
// Assumes the map header on the include path and the crystal model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "cdps_map.svh"
module clock_divide_power_status_tb;
  // ----------------
  // Signals
  // ----------------
  logic        core_clk_i, arst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic        ale_request_i, ext_mem_access_i, external_data_move_i, wait_n_i, crystal_clk_i;
  logic [9:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [5:0]  ev;        // Pulses: irq, rx, hi, ret, pd, lo
  logic [3:0]  act, flg;  // Serial start and flag pulses
  logic [1:0]  sel;
  logic        tick, xdis, xsrc, strobe, xram, xwait;
  int          bad_count, n_tests, seed, g, k;
  // Short warm-up clock count keeps the warm-up wait brief
  cdps_top #(.WARM_CLOCKS(8)) cdps_top_i (.core_clk_i, .arst_n_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'h1), .avs_readdata_o, .avs_waitrequest_o,
    .ext_irq_vector_i(ev[0]), .serial_rx_switch_i(ev[1]), .isr_enter_hi_i(ev[2]),
    .isr_enter_lo_i(ev[5]), .return_from_interrupt_i(ev[3]), .serial_activity_start_i(act),
    .serial_flag_set_i(flg), .power_down_exit_i(ev[4]), .ale_request_i, .ext_mem_access_i,
    .external_data_move_i, .crystal_clk_i, .wait_n_i, .clock_divide_sel_o(sel),
    .machine_cycle_tick_o(tick), .crystal_disable_o(xdis), .crystal_source_select_o(xsrc),
    .latch_strobe_o(strobe), .onchip_xram_enable_o(xram), .xdata_wait_o(xwait));
  cdps_xtal_model cdps_xtal_model_i (.crystal_disable_i(xdis), .crystal_clk_o(crystal_clk_i));
  // ----------------
  // Shared tasks
  // ----------------
  task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One Avalon cycle; an edge passes first so a request never re-rises in the release step
  task automatic bus(input bit wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge core_clk_i);
    avs_address_i   <= {idx, 2'h0};
    avs_writedata_i <= {24'h0, wd};
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, idx, d, x);
    // Registered outputs follow the write one edge later; let them settle before checks
    repeat (2) @(posedge core_clk_i);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] x;
    bus(1'b0, idx, 8'h00, x);
    check("register", {3'h0, x}, {3'h0, exp});
  endtask
  // One-cycle event pulse, then time for its effect to land
  task automatic pulse(input int b);
    @(posedge core_clk_i);
    ev[b] <= 1'b1;
    @(posedge core_clk_i);
    ev <= 6'h00;
    repeat (2) @(posedge core_clk_i);
  endtask
  // Clocks from one machine tick to the next
  task automatic tick_gap(output int n);
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (tick !== 1'b1);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ----------------
  // Clock and watchdog
  // ----------------
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  // Longest scenario is the slow divide, a few thousand clocks
  initial begin
    repeat (30000) @(posedge core_clk_i);
    bad_count++;
    finish_test();
  end
  // ----------------
  // Main sequence
  // ----------------
  initial begin
    {arst_n_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
    {ev, act, flg, ale_request_i, ext_mem_access_i, external_data_move_i} = '0;
    wait_n_i = 1'b1;
    seed = 32'hfc8c;
    repeat (10) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    rd(`CDPS_IDX_STATUS, 8'h10);
    rd(`CDPS_IDX_PWR_MGMT, 8'h40);
    k = $random(seed);
    wr(8'(k) & 8'h3f, 8'(k >> 8));
    rd(8'(k) & 8'h3f, 8'h00);
    // Each slow setting entered and left through divide-by-4
    for (int c = 1; c < 4; c++) begin
      wr(`CDPS_IDX_PWR_MGMT, 8'(c << 6));
      tick_gap(g);
      tick_gap(g);
      check("tick gap", 11'(g), 11'(4 << (4 * (c - 1))));
      wr(`CDPS_IDX_PWR_MGMT, 8'h40);
    end
    wr(`CDPS_IDX_PWR_MGMT, 8'h00);
    check("reserved code", {9'h0, sel}, 11'h1);
    // Interrupt vector then receive start both fall back to divide-by-4
    for (int b = 0; b < 2; b++) begin
      wr(`CDPS_IDX_PWR_MGMT, 8'ha0);
      pulse(b);
      check("switchback", {9'h0, sel}, 11'h1);
    end
    // Random serial port busy blocks a divide change
    k = $unsigned($random(seed)) % 4;
    act <= 4'(1 << k);
    @(posedge core_clk_i);
    act <= 4'h0;
    rd(`CDPS_IDX_STATUS, 8'h10 | 8'(1 << k));
    wr(`CDPS_IDX_PWR_MGMT, 8'ha0);
    check("busy divide", {9'h0, sel}, 11'h1);
    flg <= 4'(1 << k);
    @(posedge core_clk_i);
    flg <= 4'h0;
    rd(`CDPS_IDX_STATUS, 8'h10);
    pulse(2);
    pulse(5);
    rd(`CDPS_IDX_STATUS, 8'h70);
    pulse(3);
    rd(`CDPS_IDX_STATUS, 8'h30);
    // Protected wait enable
    wr(`CDPS_IDX_MAP_WAIT, 8'h01);
    rd(`CDPS_IDX_MAP_WAIT, 8'h00);
    wr(`CDPS_IDX_KEY, `CDPS_KEY_FIRST);
    wr(`CDPS_IDX_KEY, `CDPS_KEY_SECOND);
    wr(`CDPS_IDX_MAP_WAIT, 8'h01);
    rd(`CDPS_IDX_MAP_WAIT, 8'h01);
    repeat (20) @(posedge core_clk_i);
    wr(`CDPS_IDX_MAP_WAIT, 8'h00);
    rd(`CDPS_IDX_MAP_WAIT, 8'h01);
    wait_n_i <= 1'b0;
    external_data_move_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    check("wait stretch", {10'h0, xwait}, 11'h1);
    // Strobe suppress with on-chip SRAM mapped
    wr(`CDPS_IDX_PWR_MGMT, 8'h45);
    ale_request_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    check("sram enable", {10'h0, xram}, 11'h1);
    check("strobe held", {10'h0, strobe}, 11'h0);
    ext_mem_access_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    check("strobe ext", {10'h0, strobe}, 11'h1);
    // Crystal stop, restart, warm-up, then source select
    wr(`CDPS_IDX_PWR_MGMT, 8'h4d);
    check("xtal stop", {10'h0, xdis}, 11'h1);
    wr(`CDPS_IDX_PWR_MGMT, 8'h45);
    rd(`CDPS_IDX_STATUS, 8'h20);
    wr(`CDPS_IDX_OSC_CTRL, 8'h01);
    rd(`CDPS_IDX_OSC_CTRL, 8'h00);
    repeat (200) @(posedge core_clk_i);
    rd(`CDPS_IDX_STATUS, 8'h30);
    wr(`CDPS_IDX_OSC_CTRL, 8'h01);
    wr(`CDPS_IDX_PWR_MGMT, 8'h4d);
    check("xtal kept", {9'h0, xsrc, xdis}, 11'h2);
    // Power-down exit restarts the crystal and clears warm status
    pulse(4);
    rd(`CDPS_IDX_STATUS, 8'h20);
    finish_test();
  end
endmodule // clock_divide_power_status_tb
`default_nettype wire
